// ==== src/gpfs_map.vh ====
// Purpose: Offsets, field positions, reset values and timing counts of the pin function block
// Assumes: Byte-addressed plain register port, 32-bit data
// Notes:   Definitions only
`ifndef GPFS_MAP_VH
`define GPFS_MAP_VH
`define GPFS_ADDR_W          8
`define GPFS_OFS_FUNC_SEL    8'h00
`define GPFS_OFS_BLINK       8'h04
`define GPFS_OFS_STATUS      8'h08
`define GPFS_FUNC_RESET      32'h00000000
`define GPFS_FUNC_MASK       32'h00ffffc0
`define GPFS_BLINK_RESET     8'h20
`define GPFS_BLINK_W         8
`define GPFS_SEL_LSB0        6
`define GPFS_SEL_W           2
`define GPFS_NUM_PINS        9
`define GPFS_CODE_DEDICATED  2'h1
`define GPFS_CODE_DEFAULT    2'h0
`define GPFS_TICK_NS         14'd10000
`define GPFS_CLK_NS          14'd100
`define GPFS_TICK_CYC        (`GPFS_TICK_NS / `GPFS_CLK_NS)
`endif

// ==== src/gpfs_led_timer.v ====
// Purpose: One LED driver: stretches an event or a level by the blink time
// Assumes: Inputs on the same clock; tick is a one-cycle pulse
// Notes:   Output held for blink ticks after the last cause, the first of them possibly partial
`timescale 1ns/1ps
module gpfs_led_timer
#(
   parameter BLINK_W = 8
)
(
   // Clock and reset
   input  wire               clk,
   input  wire               reset_n,
   // Control
   input  wire               tick,
   input  wire               cause,
   input  wire [BLINK_W-1:0] blink,
   // Output
   output reg                led_ff
);
   reg  [BLINK_W-1:0] count_ff;
   reg  [BLINK_W-1:0] nxt_count;

   // Reload on cause, count down on tick
   always @*
   begin
      nxt_count = count_ff;
      if (cause)
         nxt_count = blink;
      else if (tick && count_ff != {BLINK_W{1'b0}})
         nxt_count = count_ff - {{(BLINK_W-1){1'b0}}, 1'b1};
   end

   // Counter and output flops
   always @(posedge clk or negedge reset_n)
   begin
      if (!reset_n)
      begin
         count_ff <= {BLINK_W{1'b0}};
         led_ff   <= 1'b0;
      end
      else
      begin
         count_ff <= nxt_count;
         led_ff   <= cause | (nxt_count != {BLINK_W{1'b0}});
      end
   end
endmodule // gpfs_led_timer

// ==== src/gpfs_pin_mux.v ====
// Purpose: Pin function multiplexer for nine multi-purpose pins with LED drivers
// Assumes: 10 MHz REF_CLK; event inputs come from logic on the same clock
// Notes:   Pin 7 input passes two flops before use
// Notes on behaviour
// R1: Pin 0 selector: 00 general I/O (reset), 01 receive-good LED.
// R2: Receive-good LED pulses for blink time after each good-CRC frame; the code may end it up to one tick short.
// R3: Pin 1 selector: 00 general I/O (reset), 01 frame-delimiter LED.
// R4: Frame-delimiter LED pulses for blink time when start delimiter seen; the code may end it up to one tick short.
// R5: Pin 2 selector: 00 general I/O (reset), 01 receive-active LED.
// R6: Receive-active LED on while receiver on, then at least blink time; the code may end it up to one tick short.
// R7: Pin 3 selector: 00 general I/O (reset), 01 transmit LED.
// R8: Transmit LED pulses for blink time after each sent frame; the code may end it up to one tick short.
// R9: Pin 4 selector: 00 general I/O (reset), 01 amplifier enable.
// R10: Pin 5 selector: 00 general I/O (reset), 01 transmit switch enable.
// R11: Pin 6 selector: 00 general I/O (reset), 01 receive switch enable.
// R12: Pin 7 selector: 00 sync input (reset), 01 general I/O.
// R13: Pin 8 selector: 00 interrupt output (reset).
// R14: Pin 8 selector code 01 selects general I/O.
// R15: Software never writes codes 10 or 11 into any selector.
// R16: Software writes zero to reserved bits 5..0 and 31..24.
// R17: Selector register is 32-bit read-write at offset 00, cleared at reset.
//
// The implementer's own choice: strobed register access.
`timescale 1ns/1ps
`include "gpfs_map.vh"
module gpfs_pin_mux
#(
   parameter NUM_PINS = `GPFS_NUM_PINS,
   parameter BLINK_W  = `GPFS_BLINK_W
)
(
   // Clock and reset
   input  wire                    REF_CLK,
   input  wire                    RESET_N,
   // Register port
   input  wire [`GPFS_ADDR_W-1:0] REG_ADDR,
   input  wire [31:0]             REG_WDATA,
   input  wire                    REG_WR,
   input  wire                    REG_RD,
   output reg  [31:0]             REG_RDATA,
   // Radio events and levels
   input  wire                    RX_GOOD_FRAME,
   input  wire                    RX_FRAME_DELIM,
   input  wire                    RX_ENABLED,
   input  wire                    TX_FRAME_DONE,
   input  wire                    AMP_ENABLE,
   input  wire                    TX_SWITCH_ENABLE,
   input  wire                    RX_SWITCH_ENABLE,
   input  wire                    IRQ_REQUEST,
   // General I/O core side
   input  wire [NUM_PINS-1:0]     GPIO_OUT,
   input  wire [NUM_PINS-1:0]     GPIO_OE,
   output reg  [NUM_PINS-1:0]     GPIO_IN,
   output reg                     SYNC_IN,
   // Pads
   input  wire [NUM_PINS-1:0]     PIN_I,
   output reg  [NUM_PINS-1:0]     PIN_O,
   output reg  [NUM_PINS-1:0]     PIN_OE
);
   localparam [13:0] TICK_CYC = `GPFS_TICK_CYC;

   reg  [31:0]           func_sel_ff;
   reg  [BLINK_W-1:0]    blink_ff;
   reg  [13:0]           tick_cnt_ff;
   reg                   tick_ff;
   reg  [NUM_PINS-1:0]   pin_meta_ff;
   reg  [NUM_PINS-1:0]   pin_sync_ff;
   wire [3:0]            led_w;
   wire [3:0]            led_cause;
   reg  [NUM_PINS-1:0]   ded_val;
   reg  [NUM_PINS-1:0]   ded_oe;
   wire [NUM_PINS-1:0]   is_gpio;
   wire [NUM_PINS-1:0]   nxt_pin_o;
   wire [NUM_PINS-1:0]   nxt_pin_oe;
   reg  [NUM_PINS-1:0]   nxt_gpio_in;
   reg                   nxt_sync_in;
   reg  [31:0]           nxt_rdata;
   reg  [31:0]           nxt_func_sel;
   reg  [BLINK_W-1:0]    nxt_blink;
   reg  [13:0]           nxt_tick_cnt;
   reg                   nxt_tick;
   wire                  tick_wrap;
   wire                  hit_func_sel;
   wire                  hit_blink;
   wire                  hit_status;
   wire [31:0]           status_word;

   // Selector field of one pin
   function [1:0] sel_of;
      input [31:0] reg_val;
      input integer pin;
      begin
         sel_of = reg_val[`GPFS_SEL_LSB0 + 2*pin +: `GPFS_SEL_W];
      end
   endfunction

   // Register port address match
   function addr_is;
      input [`GPFS_ADDR_W-1:0] addr;
      input [`GPFS_ADDR_W-1:0] ofs;
      begin
         addr_is = (addr == ofs);
      end
   endfunction

   // General I/O or dedicated function for one selector code;
   // pins 7 and 8 default to their function, the others to general I/O,
   // so a reserved code falls back to the reset behaviour of its pin
   function code_is_gpio;
      input [1:0]   code;
      input integer pin;
      begin
         if (pin < 7)
            code_is_gpio = (code != `GPFS_CODE_DEDICATED);
         else
            code_is_gpio = (code == `GPFS_CODE_DEDICATED);
      end
   endfunction

   // Address decode for the write path; the read path decodes REG_ADDR in its own case
   assign hit_func_sel = addr_is(REG_ADDR, `GPFS_OFS_FUNC_SEL);
   assign hit_blink    = addr_is(REG_ADDR, `GPFS_OFS_BLINK);
   assign hit_status   = addr_is(REG_ADDR, `GPFS_OFS_STATUS);

   // Next selector and blink values; reserved selector bits never stored
   // Writes to other offsets, the status word included, are ignored
   always @*
   begin
      nxt_func_sel = func_sel_ff;
      nxt_blink    = blink_ff;
      if (REG_WR && hit_func_sel)
         nxt_func_sel = REG_WDATA & `GPFS_FUNC_MASK; // R17 R16
      if (REG_WR && hit_blink)
         nxt_blink = REG_WDATA[BLINK_W-1:0];
   end

   // Selector register and blink time
   always @(posedge REF_CLK or negedge RESET_N)
   begin
      if (!RESET_N)
      begin
         func_sel_ff <= `GPFS_FUNC_RESET; // R17
         blink_ff    <= `GPFS_BLINK_RESET;
      end
      else
      begin
         func_sel_ff <= nxt_func_sel;
         blink_ff    <= nxt_blink;
      end
   end

   // Read data one cycle after the strobe, zero otherwise
   always @*
   begin
      nxt_rdata = 32'h00000000;
      if (REG_RD)
      begin
         case (REG_ADDR)
            `GPFS_OFS_FUNC_SEL: nxt_rdata = func_sel_ff; // R17
            `GPFS_OFS_BLINK:    nxt_rdata = {{(32-BLINK_W){1'b0}}, blink_ff};
            `GPFS_OFS_STATUS:   nxt_rdata = status_word;
            default:            nxt_rdata = 32'h00000000;
         endcase
      end
   end

   // Status word: LED drive states above the synchronised pads
   assign status_word = {{(32-4-NUM_PINS){1'b0}}, led_w, pin_sync_ff};

   // Blink tick every 10 us; the counter wraps so ticks never drift
   // A stretcher may see its first tick early, so an LED can end one tick short
   assign tick_wrap = (tick_cnt_ff == TICK_CYC - 14'h0001);

   // Next tick counter value
   always @*
   begin
      nxt_tick_cnt = tick_wrap ? 14'h0000 : tick_cnt_ff + 14'h0001;
      nxt_tick     = tick_wrap;
   end

   // Tick counter and tick pulse
   always @(posedge REF_CLK or negedge RESET_N)
   begin
      if (!RESET_N)
      begin
         tick_cnt_ff <= 14'h0000;
         tick_ff     <= 1'b0;
      end
      else
      begin
         tick_ff     <= nxt_tick;
         tick_cnt_ff <= nxt_tick_cnt;
      end
   end

   // LED causes
   assign led_cause[0] = RX_GOOD_FRAME;  // R2
   assign led_cause[1] = RX_FRAME_DELIM; // R4
   assign led_cause[2] = RX_ENABLED;     // R6
   assign led_cause[3] = TX_FRAME_DONE;  // R8

   // One stretcher per LED
   genvar g;
   generate
      for (g = 0; g < 4; g = g + 1)
      begin : g_led
         gpfs_led_timer #(.BLINK_W(BLINK_W)) u_led
         (
            .clk     (REF_CLK),
            .reset_n (RESET_N),
            .tick    (tick_ff),
            .cause   (led_cause[g]),
            .blink   (blink_ff),
            .led_ff  (led_w[g])
         );
      end
   endgenerate

   // Dedicated function of each pin; only pin 7 is an input,
   // every other function pin is driven whenever it is selected
   always @*
   begin
      ded_val = {NUM_PINS{1'b0}};
      ded_oe  = {NUM_PINS{1'b1}};
      ded_val[3:0] = led_w;            // R2 R4 R6 R8
      ded_val[4]   = AMP_ENABLE;       // R9
      ded_val[5]   = TX_SWITCH_ENABLE; // R10
      ded_val[6]   = RX_SWITCH_ENABLE; // R11
      ded_oe[7]    = 1'b0;             // R12
      ded_val[8]   = IRQ_REQUEST;      // R13
   end

   // Per-pin choice between general I/O and the dedicated function
   // Pad drive is registered below so each pad output leaves a flop
   generate
      for (g = 0; g < NUM_PINS; g = g + 1)
      begin : g_pin
         assign is_gpio[g]    = code_is_gpio(sel_of(func_sel_ff, g), g); // R1 R3 R5 R7 R9 R10 R11 R12 R14
         assign nxt_pin_o[g]  = is_gpio[g] ? GPIO_OUT[g] : ded_val[g];
         assign nxt_pin_oe[g] = is_gpio[g] ? GPIO_OE[g] : ded_oe[g]; // R13
      end
   endgenerate

   // Pad values seen by the core; the sync input only in its own mode
   always @*
   begin
      nxt_gpio_in = pin_sync_ff & is_gpio;
      nxt_sync_in = pin_sync_ff[7] & ~is_gpio[7]; // R12
   end

   // Two-flop synchroniser for the pads
   // Only the second stage is read by any logic
   always @(posedge REF_CLK or negedge RESET_N)
   begin
      if (!RESET_N)
      begin
         pin_meta_ff <= {NUM_PINS{1'b0}};
         pin_sync_ff <= {NUM_PINS{1'b0}};
      end
      else
      begin
         pin_meta_ff <= PIN_I;
         pin_sync_ff <= pin_meta_ff;
      end
   end

   // Core-side input flops
   always @(posedge REF_CLK or negedge RESET_N)
   begin
      if (!RESET_N)
      begin
         GPIO_IN <= {NUM_PINS{1'b0}};
         SYNC_IN <= 1'b0;
      end
      else
      begin
         GPIO_IN <= nxt_gpio_in;
         SYNC_IN <= nxt_sync_in; // R12
      end
   end

   // Pad drive flops
   always @(posedge REF_CLK or negedge RESET_N)
   begin
      if (!RESET_N)
      begin
         PIN_O  <= {NUM_PINS{1'b0}};
         PIN_OE <= {NUM_PINS{1'b0}};
      end
      else
      begin
         PIN_O  <= nxt_pin_o;
         PIN_OE <= nxt_pin_oe;
      end
   end

   // Read data flop, zero outside the cycle after a read
   always @(posedge REF_CLK or negedge RESET_N)
   begin
      if (!RESET_N)
         REG_RDATA <= 32'h00000000;
      else
         REG_RDATA <= nxt_rdata;
   end
endmodule // gpfs_pin_mux

// ==== verif/gpfs_pin_mux_properties.sv ====
// Purpose: Port-level checks of the pin function block
// Assumes: Selector register shadowed from the register writes
// Notes:   Bound to gpfs_pin_mux
`timescale 1ns/1ps
`include "gpfs_map.vh"
module gpfs_pin_mux_props
#(
   parameter NUM_PINS = 9
)
(
   // Clock, reset and register port
   input logic                    REF_CLK,
   input logic                    RESET_N,
   input logic [`GPFS_ADDR_W-1:0] REG_ADDR,
   input logic [31:0]             REG_WDATA,
   input logic                    REG_WR,
   input logic                    REG_RD,
   input logic [31:0]             REG_RDATA,
   // Function sources
   input logic                    RX_GOOD_FRAME,
   input logic                    RX_ENABLED,
   input logic                    AMP_ENABLE,
   input logic                    TX_SWITCH_ENABLE,
   input logic                    RX_SWITCH_ENABLE,
   input logic                    IRQ_REQUEST,
   // Core side and pads
   input logic [NUM_PINS-1:0]     GPIO_OUT,
   input logic [NUM_PINS-1:0]     GPIO_OE,
   input logic [NUM_PINS-1:0]     PIN_O,
   input logic [NUM_PINS-1:0]     PIN_OE
);
   logic [31:0] sel_ff;
   logic [1:0]  up_ff;
   default clocking @(posedge REF_CLK); endclocking
   default disable iff (!RESET_N);
   // Selector shadow; run-in skips the edges whose history lies in reset
   always_ff @(posedge REF_CLK or negedge RESET_N)
      if (!RESET_N)
      begin
         sel_ff <= 32'h0;
         up_ff  <= 2'h0;
      end
      else
      begin
         up_ff <= {up_ff[0], 1'b1};
         if (REG_WR && REG_ADDR == `GPFS_OFS_FUNC_SEL)
            sel_ff <= REG_WDATA & `GPFS_FUNC_MASK;
      end
   sel_read_a: assert property (REG_RD && REG_ADDR == `GPFS_OFS_FUNC_SEL |=> REG_RDATA == $past(sel_ff))
      else $error("selector read-back wrong");
   pin0_gpio_a: assert property (up_ff[1] && $past(sel_ff[7:6]) != 2'h1 |->
      {PIN_OE[0], PIN_O[0]} == $past({GPIO_OE[0], GPIO_OUT[0]})) else $error("pin 0 not general I/O");
   good_led_a: assert property (up_ff[1] && sel_ff[7:6] == 2'h1 && $past(RX_GOOD_FRAME) |=> PIN_O[0])
      else $error("receive-good LED missing");
   rx_led_a: assert property (up_ff[1] && sel_ff[11:10] == 2'h1 && $past(RX_ENABLED) |=> PIN_O[2])
      else $error("receive-active LED off");
   amp_route_a: assert property (up_ff[1] && $past(sel_ff[15:14]) == 2'h1 |->
      PIN_OE[4] && PIN_O[4] == $past(AMP_ENABLE)) else $error("amplifier enable not routed");
   tx_switch_a: assert property (up_ff[1] && $past(sel_ff[17:16]) == 2'h1 |->
      PIN_OE[5] && PIN_O[5] == $past(TX_SWITCH_ENABLE)) else $error("transmit switch not routed");
   rx_switch_a: assert property (up_ff[1] && $past(sel_ff[19:18]) == 2'h1 |->
      PIN_OE[6] && PIN_O[6] == $past(RX_SWITCH_ENABLE)) else $error("receive switch not routed");
   sync_input_a: assert property (up_ff[1] && $past(sel_ff[21:20]) == 2'h0 |-> !PIN_OE[7])
      else $error("sync pin driven");
   irq_route_a: assert property (up_ff[1] && $past(sel_ff[23:22]) == 2'h0 |->
      PIN_OE[8] && PIN_O[8] == $past(IRQ_REQUEST)) else $error("interrupt not routed");
   pin8_gpio_a: assert property (up_ff[1] && $past(sel_ff[23:22]) == 2'h1 |->
      {PIN_OE[8], PIN_O[8]} == $past({GPIO_OE[8], GPIO_OUT[8]})) else $error("pin 8 not general I/O");
endmodule // gpfs_pin_mux_props
bind gpfs_pin_mux gpfs_pin_mux_props #(.NUM_PINS(NUM_PINS)) chk (.REF_CLK, .RESET_N, .REG_ADDR, .REG_WDATA,
   .REG_WR, .REG_RD, .REG_RDATA, .RX_GOOD_FRAME, .RX_ENABLED, .AMP_ENABLE, .TX_SWITCH_ENABLE,
   .RX_SWITCH_ENABLE, .IRQ_REQUEST, .GPIO_OUT, .GPIO_OE, .PIN_O, .PIN_OE);

// ==== verif/gpfs_pad_model.sv ====
// Purpose: Pads, LEDs and loads beyond the pin function block
// Assumes: One clock
// Notes:   Undriven pads wander every cycle
`timescale 1ns/1ps
module gpfs_pad_model
(
   // Clock
   input  logic       clk,
   // Pad side
   input  logic [8:0] pin_o,
   input  logic [8:0] pin_oe,
   output logic [8:0] pin_i,
   // Last LED on time per LED pin, in cycles
   output int         led_len [4]
);
   int         run [4] = '{0, 0, 0, 0};
   logic [8:0] pat     = 9'h0a5;
   // Released pads change every cycle, driven pads read back
   always @(posedge clk)
      pat <= ~pat;
   assign pin_i = (pin_o & pin_oe) | (pat & ~pin_oe);
   // LED on time latched when each pulse ends
   always @(posedge clk)
      for (int i = 0; i < 4; i++)
         if (pin_o[i])
            run[i]++;
         else
         begin
            if (run[i] > 0)
               led_len[i] = run[i];
            run[i] = 0;
         end
endmodule // gpfs_pad_model

// ==== verif/tb_gpio_pin_function_select.sv ====
// Purpose: Self-checking bench of the pin function block
// Assumes: 10 MHz clock, plain register port
// Notes:   Reads are checked by a monitor from a queue
`timescale 1ns/1ps
`include "gpfs_map.vh"
module tb_gpio_pin_function_select;
   logic        clk = 0, rst_n = 0, wr = 0, rd = 0, rd_d = 0, sync;
   logic [7:0]  addr = 0;
   logic [31:0] wdata = 0, rdata, mode = 0, raw, exp_q [$];
   logic [3:0]  ev = 0, lv = 0;
   logic [8:0]  gout = 0, goe = 0, gin, pin_i, pin_o, pin_oe;
   logic [26:0] pin_h;
   int          led_len [4], error_cnt = 0, comparisons = 0;
   gpfs_pin_mux dut (.REF_CLK(clk), .RESET_N(rst_n), .REG_ADDR(addr), .REG_WDATA(wdata), .REG_WR(wr),
      .REG_RD(rd), .REG_RDATA(rdata), .RX_GOOD_FRAME(ev[0]), .RX_FRAME_DELIM(ev[1]), .RX_ENABLED(ev[2]),
      .TX_FRAME_DONE(ev[3]), .AMP_ENABLE(lv[0]), .TX_SWITCH_ENABLE(lv[1]), .RX_SWITCH_ENABLE(lv[2]),
      .IRQ_REQUEST(lv[3]), .GPIO_OUT(gout), .GPIO_OE(goe), .GPIO_IN(gin), .SYNC_IN(sync), .PIN_I(pin_i),
      .PIN_O(pin_o), .PIN_OE(pin_oe));
   gpfs_pad_model pm (.clk(clk), .pin_o(pin_o), .pin_oe(pin_oe), .pin_i(pin_i), .led_len(led_len));
   // Clock
   initial
      forever #50 clk = ~clk;
   task automatic check(input logic [31:0] seen, input logic [31:0] exp, input string what);
      comparisons++;
      if (seen !== exp)
      begin
         error_cnt++;
         $display("unexpected %s: expected %h, seen %h", what, exp, seen);
      end
   endtask
   task automatic reg_acc(input logic w, input logic [7:0] a, input logic [31:0] d);
      @(posedge clk);
      wr <= w;
      rd <= !w;
      addr <= a;
      wdata <= d;
      if (!w)
         exp_q.push_back(d);
      @(posedge clk);
      wr <= 0;
      rd <= 0;
   endtask
   // Random traffic on general I/O and function levels, pads compared one cycle later
   task automatic pads(input int n);
      logic [1:0] c;
      logic       g;
      for (int k = 0; k < n; k++)
      begin
         @(posedge clk);
         gout <= 9'($urandom);
         goe <= 9'($urandom);
         lv <= 4'($urandom);
         @(posedge clk);
         @(negedge clk);
         check(sync, pin_h[25] & (mode[21:20] != 2'h1), "sync input");
         for (int i = 0; i < 9; i++)
         begin
            c = mode[7+2*i -: 2];
            g = (i < 7) ? (c != 2'h1) : (c == 2'h1);
            check(gin[i], pin_h[18+i] & g, "gpio input");
            if (g)
               check({pin_oe[i], pin_o[i]}, {goe[i], gout[i]}, "gpio pad");
            else if (i == 7)
               check(pin_oe[7], 0, "sync pad");
            else if (i > 3)
               check({pin_oe[i], pin_o[i]}, {1'b1, lv[i == 8 ? 3 : i-4]}, "function pad");
         end
      end
   endtask
   task automatic give_verdict;
      $display("comparisons %0d, errors %0d", comparisons, error_cnt);
      if (error_cnt == 0 && comparisons > 0)
         $display("All tests passed");
      else
         $display("Some tests failed");
      $finish;
   endtask
   // Read data stand in the cycle after the strobe
   always @(posedge clk)
      rd_d <= rd;
   // Pad history: core inputs show the pad two edges back
   always @(posedge clk)
      pin_h <= {pin_h[17:0], pin_i};
   always @(negedge clk)
      if (rd_d)
         check(rdata, exp_q.pop_front(), "read data");
   // Main sequence
   initial
   begin
      void'($urandom(4614));
      repeat (3) @(posedge clk);
      rst_n <= 1;
      reg_acc(0, 8'h00, 32'h0);
      reg_acc(0, 8'h0c, 32'h0);
      reg_acc(0, 8'h04, `GPFS_BLINK_RESET);
      pads(6);
      mode = 32'h00555540;
      reg_acc(1, 8'h00, mode);
      reg_acc(0, 8'h00, mode);
      pads(10);
      repeat (6)
      begin
         raw = $urandom & 32'h00555540;
         mode = raw & `GPFS_FUNC_MASK;
         reg_acc(1, 8'h00, raw);
         reg_acc(0, 8'h00, mode);
         pads(4);
      end
      reg_acc(1, 8'h04, 32'h4);
      mode = 32'h00001540;
      reg_acc(1, 8'h00, mode);
      for (int i = 0; i < 4; i++)
      begin
         ev[i] <= 1;
         repeat (i == 2 ? 50 : 1) @(posedge clk);
         ev[i] <= 0;
         repeat (600) @(posedge clk);
         check(led_len[i] >= (i == 2 ? 349 : 300) && led_len[i] <= (i == 2 ? 451 : 401), 1, "led time");
      end
      give_verdict();
   end
   // Watchdog
   initial
   begin
      #(20000 * 100);
      error_cnt++;
      give_verdict();
   end
endmodule // tb_gpio_pin_function_select
